// >>> inc/adcctl_pkg.sv
package adcctl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CONV_CONTROL = 8'hD9;
    localparam logic [7:0] ADDR_INPUT_CONTROL = 8'hDA;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hDC;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hDD;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hE0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hE1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] INPUT_RESET = 8'h00;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int BIT_DONE = 7;
    localparam int BIT_START_BUSY = 6;
    localparam int BIT_OUTPUT_MODE = 5;
    localparam int BIT_ENABLE = 4;
    localparam int BIT_LEFT_JUSTIFY = 3;
    localparam int CLKSEL_LSB = 0;
    localparam int TRIG_LSB = 4;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVERRUN = 1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int INPUT_CONV_CYCLES = 13;
    localparam int OUTPUT_CONV_CYCLES = 11;
    localparam int SAMPLE_CYCLE = 3;
    localparam int RC_DIV = 4;
    localparam int RESULT_BITS = 10;
    localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
endpackage

// >>> design/adcctl_clkdiv.sv
// ****************************************
// Converter clock enable generator
// ****************************************
module adcctl_clkdiv
    import adcctl_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic rc_tick,
    input wire logic [2:0] clk_select,
    output logic conv_tick
);
    logic [6:0] presc_r;
    logic [1:0] rc_cnt_r;

    // Free running prescaler; tap n marks a wrap of fsys/2^n
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            presc_r <= 7'h00;
        else
            presc_r <= presc_r + 7'h01;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rc_cnt_r <= 2'h0;
        else if (rc_tick)
            rc_cnt_r <= rc_cnt_r + 2'h1;
    end

    always_comb
    begin
        if (clk_select == 3'h0)
            conv_tick = rc_tick && (rc_cnt_r == 2'(RC_DIV - 1));
        else
            conv_tick = ((presc_r & ((7'h01 << (clk_select - 3'h1)) - 7'h01 | (7'h01 << (clk_select - 3'h1))))
                == ((7'h01 << (clk_select - 3'h1)) - 7'h01 | (7'h01 << (clk_select - 3'h1))));
    end
endmodule

// >>> design/adcctl_top.sv
// Design decision made here: the strobed register port.
module adcctl_top
    import adcctl_pkg::*;
#(
    parameter int DATA_BITS = RESULT_BITS
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic int_ack,
    input wire logic rc_tick,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic [9:0] core_result,
    output logic core_enable,
    output logic core_output_mode,
    output logic core_sample,
    output logic core_step,
    output logic [9:0] core_dac_value,
    output logic irq
);
    import adcctl_pkg::*;

    // The port widths are fixed at ten bits
    if (DATA_BITS != RESULT_BITS)
    begin : g_width_check
        $error("adcctl_top serves only 10-bit data");
    end

    typedef enum logic [2:0] {
        ADCCTL_IDLE = 3'b001,
        ADCCTL_RUN = 3'b010,
        ADCCTL_FINISH = 3'b100
    } adcctl_state_t;

    adcctl_state_t state_r;
    logic [7:0] ctrl_r;
    logic [7:0] input_r;
    logic [15:0] result_r;
    logic [15:0] out_data_r;
    logic [9:0] dac_buf_r;
    logic [3:0] cycle_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic conv_tick;
    logic trig_ovf;
    logic start_req;
    logic conv_end;
    logic [3:0] conv_len;

    // ****************************************
    // Converter clock
    // ****************************************
    adcctl_clkdiv u_clkdiv
    (
        .clock(clock),
        .nrst(nrst),
        .rc_tick(rc_tick),
        .clk_select(ctrl_r[2:0]),
        .conv_tick(conv_tick)
    );

    // ****************************************
    // Trigger and sequencing
    // ****************************************
    function automatic logic sel_timer(input logic [1:0] trigger_select, input logic t0, input logic t1, input logic t2);
        case (trigger_select)
            2'h1: sel_timer = t0;
            2'h2: sel_timer = t1;
            2'h3: sel_timer = t2;
            default: sel_timer = 1'b0;
        endcase
    endfunction

    assign trig_ovf = sel_timer(input_r[5:4], timer0_ovf, timer1_ovf, timer2_ovf);

    logic sw_write_start;
    assign sw_write_start = wr_en && addr == ADDR_CONV_CONTROL && wdata[BIT_START_BUSY];

    // one start per request while enabled and idle
    assign start_req = ctrl_r[BIT_ENABLE] && state_r == ADCCTL_IDLE
        && (input_r[5:4] == TRIG_SOFTWARE ? sw_write_start : trig_ovf);

    assign conv_len = ctrl_r[BIT_OUTPUT_MODE] ? 4'(OUTPUT_CONV_CYCLES) : 4'(INPUT_CONV_CYCLES);
    assign conv_end = state_r == ADCCTL_RUN && conv_tick && cycle_r == conv_len;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ADCCTL_IDLE;
            cycle_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                ADCCTL_IDLE:
                begin
                    cycle_r <= 4'h0;
                    if (start_req)
                        state_r <= ADCCTL_RUN;
                end
                ADCCTL_RUN:
                begin
                    if (!ctrl_r[BIT_ENABLE])
                        state_r <= ADCCTL_IDLE;
                    else if (conv_end)
                        state_r <= ADCCTL_FINISH;
                    else if (conv_tick)
                        cycle_r <= cycle_r + 4'h1;
                end
                ADCCTL_FINISH:
                begin
                    state_r <= ADCCTL_IDLE;
                end
                default: state_r <= ADCCTL_IDLE;
            endcase
        end
    end

    // sample strobe in third converter cycle
    assign core_sample = state_r == ADCCTL_RUN && conv_tick && cycle_r == 4'(SAMPLE_CYCLE - 1)
        && !ctrl_r[BIT_OUTPUT_MODE];
    assign core_step = state_r == ADCCTL_RUN && conv_tick;
    assign core_output_mode = ctrl_r[BIT_OUTPUT_MODE];
    assign core_enable = ctrl_r[BIT_ENABLE];
    assign core_dac_value = dac_buf_r;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            dac_buf_r <= 10'h000;
        else if (start_req && ctrl_r[BIT_OUTPUT_MODE])
            dac_buf_r <= ctrl_r[BIT_LEFT_JUSTIFY] ? out_data_r[15:6] : out_data_r[9:0];
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ctrl_r <= CTRL_RESET;
        else
        begin
            if (wr_en && addr == ADDR_CONV_CONTROL)
                ctrl_r[5:0] <= wdata[5:0];
            // busy held while running, cleared at end
            if (start_req)
                ctrl_r[BIT_START_BUSY] <= 1'b1;
            else if (state_r == ADCCTL_FINISH || (state_r == ADCCTL_RUN && !ctrl_r[BIT_ENABLE]))
                ctrl_r[BIT_START_BUSY] <= 1'b0;
            else if (state_r == ADCCTL_IDLE)
                ctrl_r[BIT_START_BUSY] <= 1'b0;
            // done set wins over vector clear
            if (state_r == ADCCTL_FINISH)
                ctrl_r[BIT_DONE] <= 1'b1;
            else if (int_ack)
                ctrl_r[BIT_DONE] <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            input_r <= INPUT_RESET;
        else if (wr_en && addr == ADDR_INPUT_CONTROL)
            input_r <= wdata;
    end

    // ****************************************
    // Result data
    // ****************************************
    // justify and extend result
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            result_r <= 16'h0000;
        else if (conv_end && !ctrl_r[BIT_OUTPUT_MODE])
            result_r <= ctrl_r[BIT_LEFT_JUSTIFY] ? {core_result, 6'h00} : {{6{core_result[9]}}, core_result};
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            out_data_r <= 16'h0000;
        else if (wr_en && ctrl_r[BIT_OUTPUT_MODE])
        begin
            if (addr == ADDR_RESULT_LOW)
                out_data_r[7:0] <= wdata;
            else if (addr == ADDR_RESULT_HIGH)
                out_data_r[15:8] <= wdata;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irq_mask_r <= 2'h0;
        else if (wr_en && addr == ADDR_IRQ_MASK)
            irq_mask_r <= wdata[1:0];
    end

    // Set wins over the clear-on-read
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irq_status_r <= 2'h0;
        else
        begin
            irq_status_r <= (rd_en && addr == ADDR_IRQ_STATUS) ? 2'h0 : irq_status_r;
            if (state_r == ADCCTL_FINISH)
                irq_status_r[IRQ_DONE] <= 1'b1;
            // overflow during a busy conversion is flagged
            if (trig_ovf && state_r != ADCCTL_IDLE && input_r[5:4] != TRIG_SOFTWARE)
                irq_status_r[IRQ_OVERRUN] <= 1'b1;
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // ****************************************
    // Read port
    // ****************************************
    // read mux, result visible in input mode only
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (!rd_en)
            rdata <= 8'h00;
        else
        begin
            case (addr)
                ADDR_CONV_CONTROL: rdata <= ctrl_r;
                ADDR_INPUT_CONTROL: rdata <= input_r;
                ADDR_RESULT_LOW: rdata <= ctrl_r[BIT_OUTPUT_MODE] ? 8'h00 : result_r[7:0];
                ADDR_RESULT_HIGH: rdata <= ctrl_r[BIT_OUTPUT_MODE] ? 8'h00 : result_r[15:8];
                ADDR_IRQ_STATUS: rdata <= {6'h00, irq_status_r};
                ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask_r};
                default: rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_start;
        @(posedge clock) disable iff (!nrst) start_req |=> state_r == ADCCTL_RUN && ctrl_r[BIT_START_BUSY];
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_busy;
        @(posedge clock) disable iff (!nrst) state_r == ADCCTL_RUN && ctrl_r[BIT_ENABLE] |-> ctrl_r[BIT_START_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped mid conversion");

    property p_busy_clr;
        @(posedge clock) disable iff (!nrst) state_r == ADCCTL_FINISH |=> !ctrl_r[BIT_START_BUSY];
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");

    property p_timer_busy;
        @(posedge clock) disable iff (!nrst) start_req && input_r[5:4] != TRIG_SOFTWARE
            |=> ctrl_r[BIT_START_BUSY];
    endproperty
    a_timer_busy: assert property (p_timer_busy) else $error("busy not set by timer start");

    property p_done;
        @(posedge clock) disable iff (!nrst) state_r == ADCCTL_FINISH |=> ctrl_r[BIT_DONE];
    endproperty
    a_done: assert property (p_done) else $error("done not set");

    property p_enable;
        @(posedge clock) disable iff (!nrst) !ctrl_r[BIT_ENABLE] |=> state_r != ADCCTL_RUN;
    endproperty
    a_enable: assert property (p_enable) else $error("start while disabled");

    property p_just;
        @(posedge clock) disable iff (!nrst) conv_end && !ctrl_r[BIT_OUTPUT_MODE] && !ctrl_r[BIT_LEFT_JUSTIFY]
            |=> result_r[9:0] == $past(core_result) && result_r[15:10] == {6{result_r[9]}};
    endproperty
    a_just: assert property (p_just) else $error("sign extension wrong");

    // Step count kept apart from the sequencer so the length check is not circular
    logic [4:0] step_seen_r;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            step_seen_r <= 5'h00;
        else if (start_req)
            step_seen_r <= 5'h00;
        else if (core_step)
            step_seen_r <= step_seen_r + 5'h01;
    end

    // One alignment step precedes the full converter cycles
    property p_len;
        @(posedge clock) disable iff (!nrst) state_r == ADCCTL_FINISH
            |-> step_seen_r == (ctrl_r[BIT_OUTPUT_MODE] ? 5'(OUTPUT_CONV_CYCLES + 1) : 5'(INPUT_CONV_CYCLES + 1));
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");

    property p_ro;
        @(posedge clock) disable iff (!nrst) rd_en && addr == ADDR_RESULT_LOW && ctrl_r[BIT_OUTPUT_MODE]
            |=> rdata == 8'h00;
    endproperty
    a_ro: assert property (p_ro) else $error("result readable in output mode");

    c_in: cover property (@(posedge clock) conv_end && !ctrl_r[BIT_OUTPUT_MODE]);
    c_out: cover property (@(posedge clock) conv_end && ctrl_r[BIT_OUTPUT_MODE]);
    c_timer: cover property (@(posedge clock) start_req && input_r[5:4] != TRIG_SOFTWARE);
endmodule

// >>> verification/adcctl_core_model.sv
// ********
// Analog core stand-in: RC ticks, result, step counts
// ********
module adcctl_core_model
    import adcctl_pkg::*;
#(
    parameter logic [9:0] RESULT_VALUE = 10'h2C5
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clear_counts,
    input wire logic core_enable,
    input wire logic core_sample,
    input wire logic core_step,
    output logic rc_tick,
    output logic [9:0] core_result,
    output int step_count,
    output int sample_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] rc_div_r;
    // Roughly 8 MHz from the 125 MHz system clock
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rc_div_r <= 4'h0;
            rc_tick <= 1'b0;
        end
        else
        begin
            rc_div_r <= rc_div_r + 4'h1;
            rc_tick <= (rc_div_r == 4'hF);
        end
    end
    // Disabled core shows the inverse so a stale value is never mistaken for a result
    assign core_result = core_enable ? RESULT_VALUE : ~RESULT_VALUE;
    always_ff @(posedge clock)
    begin
        if (clear_counts)
        begin
            step_count <= 0;
            sample_count <= 0;
        end
        else
        begin
            step_count <= step_count + int'(core_step);
            sample_count <= sample_count + int'(core_sample);
        end
    end
endmodule

// >>> verification/tb_adcctl_top.sv
module tb_adcctl_top
    import adcctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] RV = 10'h2C5;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic int_ack = 1'b0;
    logic [2:0] tmr = 3'h0;
    logic clr = 1'b0;
    logic [7:0] rdata;
    logic rc_tick;
    logic core_enable;
    logic core_output_mode;
    logic core_sample;
    logic core_step;
    logic irq;
    logic [9:0] core_result;
    logic [9:0] core_dac_value;
    int steps;
    int samples;
    int num_errors = 0;
    int total_checks = 0;
    logic [7:0] v;
    int n;
    adcctl_top dut_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .int_ack(int_ack), .rc_tick(rc_tick), .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]),
        .timer2_ovf(tmr[2]), .core_result(core_result), .core_enable(core_enable),
        .core_output_mode(core_output_mode), .core_sample(core_sample), .core_step(core_step),
        .core_dac_value(core_dac_value), .irq(irq));
    adcctl_core_model #(.RESULT_VALUE(RV)) core_u (.clock(clock), .nrst(nrst), .clear_counts(clr),
        .core_enable(core_enable), .core_sample(core_sample), .core_step(core_step), .rc_tick(rc_tick),
        .core_result(core_result), .step_count(steps), .sample_count(samples));
    always #4 clock = ~clock;
    // ********
    // Bus and helper tasks
    // ********
    task automatic close_out;
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // One-cycle pulse on int_ack when ack is set, else on the count clear
    task automatic pulse(input bit ack);
        @(posedge clock);
        if (ack)
            int_ack <= 1'b1;
        else
            clr <= 1'b1;
        @(posedge clock);
        int_ack <= 1'b0;
        clr <= 1'b0;
    endtask
    // Bounded poll of the busy bit, two cycles per read
    task automatic wait_idle(output int cyc);
        logic [7:0] b;
        cyc = 0;
        do
        begin
            rd(ADDR_CONV_CONTROL, b);
            cyc += 2;
        end
        while (b[BIT_START_BUSY] !== 1'b0 && cyc < 6000);
        if (cyc >= 6000)
        begin
            num_errors++;
            close_out();
        end
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        rd(ADDR_CONV_CONTROL, v);
        check("control reset", 16'h00, 16'(v));
        rd(ADDR_RESULT_LOW, v);
        check("result low reset", 16'h00, 16'(v));
        rd(8'h00, v);
        check("unmapped read", 16'h00, 16'(v));
    endtask
    task automatic t_sw_input;
        wr(ADDR_IRQ_MASK, 8'h01);
        pulse(1'b0);
        wr(ADDR_CONV_CONTROL, 8'h11);
        wr(ADDR_CONV_CONTROL, 8'h51);
        rd(ADDR_CONV_CONTROL, v);
        check("busy at start", 16'h1, 16'(v[BIT_START_BUSY]));
        wait_idle(n);
        check("input steps", 16'h1, 16'(steps == 13 || steps == 14));
        check("sample pulses", 16'h1, 16'(samples));
        rd(ADDR_CONV_CONTROL, v);
        check("control after end", 16'h91, 16'(v));
        check("irq raised", 16'h1, 16'(irq));
        rd(ADDR_RESULT_LOW, v);
        check("right low", 16'(RV[7:0]), 16'(v));
        rd(ADDR_RESULT_HIGH, v);
        check("right high", 16'({{6{RV[9]}}, RV[9:8]}), 16'(v));
        pulse(1'b1);
        rd(ADDR_CONV_CONTROL, v);
        check("done after ack", 16'h11, 16'(v));
        rd(ADDR_IRQ_STATUS, v);
    endtask
    task automatic t_left_irq;
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CONV_CONTROL, 8'h59);
        wait_idle(n);
        check("masked irq", 16'h0, 16'(irq));
        rd(ADDR_RESULT_LOW, v);
        check("left low", 16'({RV[1:0], 6'h00}), 16'(v));
        rd(ADDR_RESULT_HIGH, v);
        check("left high", 16'(RV[9:2]), 16'(v));
        wr(ADDR_IRQ_MASK, 8'h01);
        @(posedge clock);
        #1;
        check("unmasked irq", 16'h1, 16'(irq));
        rd(ADDR_IRQ_STATUS, v);
        check("status", 16'h01, 16'(v));
        #1;
        check("irq cleared", 16'h0, 16'(irq));
        pulse(1'b1);
    endtask
    task automatic t_disabled;
        wr(ADDR_CONV_CONTROL, 8'h11);
        wr(ADDR_CONV_CONTROL, 8'h51);
        wr(ADDR_CONV_CONTROL, 8'h01);
        rd(ADDR_CONV_CONTROL, v);
        check("abort by disable", 16'h01, 16'(v));
        pulse(1'b0);
        wr(ADDR_CONV_CONTROL, 8'h41);
        rd(ADDR_CONV_CONTROL, v);
        check("start when disabled", 16'h01, 16'(v));
        check("no steps", 16'h0, 16'(steps));
    endtask
    task automatic t_dac;
        wr(ADDR_CONV_CONTROL, 8'h31);
        #1;
        check("output mode", 16'h3, 16'({core_output_mode, core_enable}));
        wr(ADDR_RESULT_LOW, 8'h34);
        wr(ADDR_RESULT_HIGH, 8'h01);
        pulse(1'b0);
        wr(ADDR_CONV_CONTROL, 8'h71);
        wr(ADDR_RESULT_LOW, 8'h00);
        wait_idle(n);
        check("dac value", 16'h134, 16'(core_dac_value));
        check("output steps", 16'h1, 16'(steps == 11 || steps == 12));
        rd(ADDR_CONV_CONTROL, v);
        check("dac done", 16'hB1, 16'(v));
        rd(ADDR_RESULT_LOW, v);
        check("write only", 16'h00, 16'(v));
        pulse(1'b1);
        rd(ADDR_IRQ_STATUS, v);
        wr(ADDR_CONV_CONTROL, 8'h11);
    endtask
    task automatic t_timer;
        for (int c = 1; c < 4; c++)
        begin
            wr(ADDR_INPUT_CONTROL, 8'(c << 4));
            repeat (2)
            begin
                @(posedge clock);
                tmr <= ~(3'h1 << (c - 1));
                @(posedge clock);
                tmr <= 3'h0;
                rd(ADDR_CONV_CONTROL, v);
                check("other timer", 16'h0, 16'(v[BIT_START_BUSY]));
                @(posedge clock);
                tmr <= 3'h1 << (c - 1);
                @(posedge clock);
                tmr <= 3'h0;
                rd(ADDR_CONV_CONTROL, v);
                check("timer start", 16'h1, 16'(v[BIT_START_BUSY]));
                wait_idle(n);
                check("timer busy span", 16'h1, 16'(n >= 24));
            end
        end
        rd(ADDR_IRQ_STATUS, v);
        check("no overrun", 16'h01, 16'(v));
        @(posedge clock);
        tmr <= 3'h4;
        @(posedge clock);
        tmr <= 3'h0;
        @(posedge clock);
        tmr <= 3'h4;
        @(posedge clock);
        tmr <= 3'h0;
        wait_idle(n);
        rd(ADDR_IRQ_STATUS, v);
        check("overrun flag", 16'h03, 16'(v));
        wr(ADDR_INPUT_CONTROL, 8'h00);
    endtask
    task automatic t_clksel;
        int d;
        for (int c = 0; c < 8; c++)
        begin
            d = (c == 0) ? 16 * RC_DIV : (1 << c);
            wr(ADDR_CONV_CONTROL, 8'h50 | 8'(c));
            wait_idle(n);
            check("conversion time", 16'h1, 16'(n >= 12 * d && n <= 15 * d + 16));
            pulse(1'b1);
        end
    endtask
    initial
    begin
        #400000;
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_sw_input();
        t_left_irq();
        t_disabled();
        t_dac();
        t_timer();
        t_clksel();
        close_out();
    end
endmodule
